// [src/acs_sequencer.sv]
// Conversion sequencer: slot pointer, modes, stop handling, flags and DMA trigger.
// Assumes one clock; conversion_clock is a one-cycle enable; inputs are synchronous.

`timescale 1ns/10ps
`default_nettype none

module acs_sequencer
#(
    parameter int CONV_CYCLES = acs_pkg::CONV_CYCLES
)
(
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          conversion_clock,
    input  wire logic                          conversion_arm,
    input  wire logic                          soft_start,
    input  wire logic                          use_soft_start,
    input  wire logic                          sample_request_input,
    input  wire logic                          sample_timer_en,
    input  wire logic                          auto_successive,
    input  wire logic [1:0]                    sequence_kind,
    input  wire logic [3:0]                    first_slot_select,
    input  wire logic                          ctl_wr,
    input  wire logic [3:0]                    ctl_wr_slot,
    input  wire logic [2:0]                    ctl_wr_reference_select,
    input  wire logic [3:0]                    ctl_wr_channel_select,
    input  wire logic                          ctl_wr_last_in_chain,
    input  wire logic [11:0]                   core_result,
    input  wire logic                          slot_rd,
    input  wire logic [3:0]                    slot_rd_idx,
    input  wire logic [15:0]                   flag_clear,
    input  wire logic [15:0]                   result_irq_enable,
    input  wire logic                          global_irq_enable,
    input  wire logic                          overrun_clear,
    input  wire logic                          trig_overrun_clear,
    output logic [11:0]                        slot_rd_data,
    output logic [15:0]                        result_ready_flag,
    output logic [15:0]                        result_irq,
    output logic                               result_overrun,
    output logic                               trigger_overrun,
    output logic                               busy,
    output logic                               dma_trigger,
    output logic                               sampling,
    output logic [3:0]                         active_channel,
    output logic [2:0]                         active_reference,
    output logic                               temp_sensor_on,
    output logic                               ref_gen_on
);

    acs_pkg::acs_state_t state_reg;
    logic [11:0] slot_mem [acs_pkg::SLOTS];
    logic [2:0]  ref_mem  [acs_pkg::SLOTS];
    logic [3:0]  chan_mem [acs_pkg::SLOTS];
    logic [15:0] last_mem_reg;
    logic [15:0] unread_reg;
    logic [3:0]  ptr_reg;
    logic [3:0]  cnt_reg;
    logic        trig_prev_reg;
    logic        start_prev_reg;
    logic        arm_prev_reg;
    logic        locked_reg;
    logic        stop_pend_reg;
    logic        mid_seq_reg;
    logic        trig_edge;
    logic        is_seq;
    logic        is_last;
    logic        conv_done;
    logic        abort_now;
    logic        seq_end;

    function automatic logic [3:0] next_slot(input logic [3:0] s);
        next_slot = (s == acs_pkg::LAST_SLOT) ? 4'h0 : s + 4'h1;
    endfunction

    function automatic logic slot_hit(input logic rd, input logic [3:0] idx, input int i);
        slot_hit = rd && (idx == 4'(i));
    endfunction

    assign is_seq    = sequence_kind[0];
    assign is_last   = last_mem_reg[ptr_reg] | ~is_seq;
    assign conv_done = (state_reg == acs_pkg::ACS_CONV) && conversion_clock
                       && (cnt_reg == 4'(CONV_CYCLES - 1));
    // Immediate abort only in single mode; other modes drain
    assign abort_now = !conversion_arm && (sequence_kind == acs_pkg::MODE_SINGLE);
    assign seq_end   = conv_done && is_last;
    // Trigger edge from the chosen source
    assign trig_edge = use_soft_start ? (soft_start && !start_prev_reg)
                                      : (sample_request_input && !trig_prev_reg);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            trig_prev_reg  <= 1'b0;
            start_prev_reg <= 1'b0;
            arm_prev_reg   <= 1'b0;
        end
        else
        begin
            trig_prev_reg  <= sample_request_input;
            start_prev_reg <= soft_start;
            arm_prev_reg   <= conversion_arm;
        end
    end

    // Control entries; writes only honoured with arm low
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            last_mem_reg <= acs_pkg::FLAGS_RESET;
            for (int i = 0; i < acs_pkg::SLOTS; i++)
            begin
                ref_mem[i]  <= 3'h0;
                chan_mem[i] <= 4'h0;
            end
        end
        else if (ctl_wr && !conversion_arm)
        begin
            ref_mem[ctl_wr_slot]      <= ctl_wr_reference_select;
            chan_mem[ctl_wr_slot]     <= ctl_wr_channel_select;
            last_mem_reg[ctl_wr_slot] <= ctl_wr_last_in_chain;
        end
    end

    // Lock: non-soft triggers in single and sequence modes need arm toggled between runs
    always_ff @(posedge clk)
    begin
        if (rst || !conversion_arm)
            locked_reg <= 1'b0;
        else if (seq_end && !use_soft_start && !sequence_kind[1])
            locked_reg <= 1'b1;
        else if (auto_successive && sample_timer_en && state_reg != acs_pkg::ACS_IDLE
                 && sequence_kind[1])
            locked_reg <= 1'b1;
    end

    // Stop request latched on arm falling in repeat or sequence modes
    always_ff @(posedge clk)
    begin
        if (rst || state_reg == acs_pkg::ACS_IDLE)
            stop_pend_reg <= 1'b0;
        else if (arm_prev_reg && !conversion_arm)
            stop_pend_reg <= 1'b1;
    end

    // Busy spans the gaps between entries of a pass that waits for triggers
    always_ff @(posedge clk)
    begin
        if (rst || abort_now || state_reg == acs_pkg::ACS_IDLE)
            mid_seq_reg <= 1'b0;
        else if (conv_done && is_seq)
            mid_seq_reg <= !is_last;
    end

    // Main sequencing
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= acs_pkg::ACS_IDLE;
            ptr_reg   <= 4'h0;
            cnt_reg   <= 4'h0;
        end
        else if (abort_now && state_reg != acs_pkg::ACS_IDLE)
            state_reg <= acs_pkg::ACS_IDLE;
        else
        begin
            unique case (state_reg)
                acs_pkg::ACS_IDLE:
                    if (trig_edge && conversion_arm && !locked_reg)
                    begin
                        ptr_reg   <= first_slot_select;
                        state_reg <= acs_pkg::ACS_SAMPLE;
                    end
                acs_pkg::ACS_SAMPLE:
                    if (conversion_clock)
                    begin
                        cnt_reg   <= 4'h0;
                        state_reg <= acs_pkg::ACS_CONV;
                    end
                acs_pkg::ACS_CONV:
                    if (conversion_clock)
                    begin
                        cnt_reg <= cnt_reg + 4'h1;
                        if (conv_done)
                        begin
                            if (is_seq && !is_last)
                                ptr_reg <= next_slot(ptr_reg);
                            if (sequence_kind == acs_pkg::MODE_SINGLE)
                                state_reg <= acs_pkg::ACS_IDLE;
                            else if (sequence_kind == acs_pkg::MODE_SEQ && is_last)
                                state_reg <= acs_pkg::ACS_IDLE;
                            else if (stop_pend_reg && is_last)
                                state_reg <= acs_pkg::ACS_IDLE;
                            else if (auto_successive && sample_timer_en)
                            begin
                                if (is_last)
                                    ptr_reg <= first_slot_select;
                                state_reg <= acs_pkg::ACS_SAMPLE;
                            end
                            else
                                state_reg <= acs_pkg::ACS_WAIT;
                        end
                    end
                acs_pkg::ACS_WAIT:
                    if (stop_pend_reg && !mid_seq_reg)
                        state_reg <= acs_pkg::ACS_IDLE;
                    else if (trig_edge && (conversion_arm || mid_seq_reg))
                    begin
                        // Outside a pass the pointer still rests on the finished entry
                        if (sequence_kind == acs_pkg::MODE_REP_SEQ && !mid_seq_reg)
                            ptr_reg <= first_slot_select;
                        state_reg <= acs_pkg::ACS_SAMPLE;
                    end
                default:
                    state_reg <= acs_pkg::ACS_IDLE;
            endcase
        end
    end

    // Ready flags; set wins over clear
    always_ff @(posedge clk)
    begin
        if (rst)
            result_ready_flag <= acs_pkg::FLAGS_RESET;
        else
        begin
            for (int i = 0; i < acs_pkg::SLOTS; i++)
            begin
                if (conv_done && ptr_reg == 4'(i))
                    result_ready_flag[i] <= 1'b1;
                else if (slot_hit(slot_rd, slot_rd_idx, i) || flag_clear[i])
                    result_ready_flag[i] <= 1'b0;
            end
        end
    end

    // Unread state survives a direct flag clear; only a slot read consumes it
    always_ff @(posedge clk)
    begin
        if (rst)
            unread_reg <= acs_pkg::FLAGS_RESET;
        else
        begin
            for (int i = 0; i < acs_pkg::SLOTS; i++)
            begin
                if (conv_done && ptr_reg == 4'(i))
                    unread_reg[i] <= 1'b1;
                else if (slot_hit(slot_rd, slot_rd_idx, i))
                    unread_reg[i] <= 1'b0;
            end
        end
    end

    // Sticky; a fresh overwrite outranks the clear
    always_ff @(posedge clk)
    begin
        if (rst)
            result_overrun <= 1'b0;
        else if (conv_done && unread_reg[ptr_reg])
            result_overrun <= 1'b1;
        else if (overrun_clear)
            result_overrun <= 1'b0;
    end

    // Slot storage is not reset; a slot reads unknown until first written
    always_ff @(posedge clk)
    begin
        if (conv_done)
            slot_mem[ptr_reg] <= core_result;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            slot_rd_data <= 12'h000;
        else if (slot_rd)
            slot_rd_data <= slot_mem[slot_rd_idx];
    end

    // Edge during sampling or conversion is a trigger overrun
    always_ff @(posedge clk)
    begin
        if (rst)
            trigger_overrun <= 1'b0;
        else if (trig_edge && (state_reg == acs_pkg::ACS_SAMPLE || state_reg == acs_pkg::ACS_CONV))
            trigger_overrun <= 1'b1;
        else if (trig_overrun_clear)
            trigger_overrun <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            dma_trigger <= 1'b0;
        else
            dma_trigger <= conv_done && (!is_seq || is_last);
    end

    // Sixteen sources: ready flags gated per slot and by the global enable
    assign result_irq       = result_ready_flag & result_irq_enable
                              & {16{global_irq_enable}};
    assign busy             = (state_reg == acs_pkg::ACS_SAMPLE)
                              || (state_reg == acs_pkg::ACS_CONV)
                              || (state_reg == acs_pkg::ACS_WAIT && mid_seq_reg);
    assign sampling         = (state_reg == acs_pkg::ACS_SAMPLE);
    assign active_channel   = chan_mem[ptr_reg];
    assign active_reference = ref_mem[ptr_reg];
    assign temp_sensor_on   = (chan_mem[ptr_reg] == acs_pkg::TEMP_SENSOR_CHAN);
    assign ref_gen_on       = temp_sensor_on;

endmodule

`default_nettype wire

// [src/acs_pkg.sv]
// Constants shared by the conversion sequencer.
// Assumes a single 100 MHz clock; converter clock arrives as an enable pulse.
package acs_pkg;
    localparam int SLOTS          = 16;
    localparam int SLOT_W         = 4;
    localparam int RESULT_W       = 12;
    localparam int CHAN_W         = 4;
    localparam int REF_W          = 3;
    localparam int CONV_CYCLES    = 13;
    localparam int CONV_CNT_W     = 4;
    localparam logic [3:0] TEMP_SENSOR_CHAN = 4'b1010;
    localparam logic [3:0] LAST_SLOT        = 4'hf;
    localparam logic [1:0] MODE_SINGLE      = 2'b00;
    localparam logic [1:0] MODE_SEQ         = 2'b01;
    localparam logic [1:0] MODE_REP_SINGLE  = 2'b10;
    localparam logic [1:0] MODE_REP_SEQ     = 2'b11;
    localparam logic [15:0] FLAGS_RESET     = 16'h0000;

    typedef enum logic [3:0]
    {
        ACS_IDLE   = 4'b0001,
        ACS_SAMPLE = 4'b0010,
        ACS_CONV   = 4'b0100,
        ACS_WAIT   = 4'b1000
    } acs_state_t;
endpackage

// [tb/acs_props.sv]
// Port-level checker for the conversion sequencer.
// Assumes binding into acs_sequencer; one clock, synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module acs_props
#(
    parameter int CONV_CYCLES = 13
)
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        conversion_clock,
    input wire logic        conversion_arm,
    input wire logic        use_soft_start,
    input wire logic        sample_request_input,
    input wire logic [1:0]  sequence_kind,
    input wire logic        slot_rd,
    input wire logic [3:0]  slot_rd_idx,
    input wire logic [15:0] result_irq_enable,
    input wire logic        global_irq_enable,
    input wire logic        overrun_clear,
    input wire logic [15:0] result_ready_flag,
    input wire logic [15:0] result_irq,
    input wire logic        result_overrun,
    input wire logic        trigger_overrun,
    input wire logic        busy,
    input wire logic        dma_trigger,
    input wire logic        sampling,
    input wire logic [3:0]  active_channel,
    input wire logic        temp_sensor_on,
    input wire logic        ref_gen_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [4:0]  cnt_reg;
    logic [15:0] flag_d_reg;
    // Counts converter clocks after sampling; each new conversion resamples
    always_ff @(posedge clk)
    begin
        if (rst || sampling)
            cnt_reg <= 5'h00;
        else if (conversion_clock && busy && cnt_reg != 5'(CONV_CYCLES))
            cnt_reg <= cnt_reg + 5'h01;
    end
    always_ff @(posedge clk)
    begin
        flag_d_reg <= rst ? 16'h0000 : result_ready_flag;
    end
    sequence s_pulse;
        dma_trigger ##1 !dma_trigger;
    endsequence
    a_irq_gating: assert property (result_irq == (result_ready_flag & result_irq_enable
        & {16{global_irq_enable}})) else $error("ready interrupt gating wrong");
    a_conv_length: assert property (|(result_ready_flag & ~flag_d_reg)
        |-> cnt_reg == CONV_CYCLES) else $error("conversion length wrong");
    a_start_armed: assert property ($rose(busy) |-> $past(conversion_arm))
        else $error("conversion started while disarmed");
    a_read_clears: assert property (slot_rd && !busy
        |=> !result_ready_flag[$past(slot_rd_idx)]) else $error("read left flag set");
    a_dma_pulse: assert property (dma_trigger |-> s_pulse)
        else $error("dma trigger longer than one cycle");
    a_temp_sensor: assert property ((active_channel == acs_pkg::TEMP_SENSOR_CHAN)
        == (temp_sensor_on && ref_gen_on)) else $error("sensor power wrong");
    a_trig_overrun: assert property ($rose(sample_request_input) && !use_soft_start
        && busy && (sampling || cnt_reg != 5'(CONV_CYCLES)) |=> trigger_overrun)
        else $error("trigger overrun missed");
    a_overrun_holds: assert property (result_overrun && !overrun_clear
        |=> result_overrun) else $error("overrun dropped");
    a_sampling_busy: assert property (sampling |-> busy)
        else $error("sampling without busy");
    a_abort_now: assert property ($fell(conversion_arm) && sequence_kind == 2'b00
        |=> !busy) else $error("abort not immediate");
endmodule
bind acs_sequencer acs_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (.*);
`default_nettype wire

// [tb/acs_far_model.sv]
// Far side: analog core result, converter clock and hardware trigger.
// Assumes the bench asks for triggers through fire, off the clock edge.
`timescale 1ns/10ps
`default_nettype none
module acs_far_model
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        fire,
    input  wire logic [7:0]  seed,
    input  wire logic [3:0]  active_channel,
    output logic             sample_request_input,
    output logic             conversion_clock,
    output logic [11:0]      core_result
);
    logic [1:0] div_reg;
    // Converter clock at a third of the system rate
    always_ff @(posedge clk)
    begin
        div_reg <= (rst || div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
    end
    assign conversion_clock = (div_reg == 2'h2);
    assign sample_request_input = fire;
    // Result names its channel so each slot's value is predictable
    assign core_result = {seed, active_channel};
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the conversion sequencer.
// Assumes acs_pkg, acs_sequencer, acs_far_model and acs_props are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); err_count++; end end
module tb;
    logic        clk, rst, conversion_clock, conversion_arm, soft_start, use_soft_start;
    logic        sample_request_input, sample_timer_en, auto_successive, ctl_wr;
    logic        ctl_wr_last_in_chain, slot_rd, global_irq_enable, overrun_clear;
    logic        trig_overrun_clear, fire, result_overrun, trigger_overrun, busy;
    logic        dma_trigger, sampling, temp_sensor_on, ref_gen_on, rd_d;
    logic [1:0]  sequence_kind;
    logic [2:0]  ctl_wr_reference_select, active_reference;
    logic [3:0]  first_slot_select, ctl_wr_slot, ctl_wr_channel_select, slot_rd_idx;
    logic [3:0]  active_channel, s;
    logic [7:0]  seed;
    logic [11:0] core_result, slot_rd_data, e_v;
    logic [15:0] flag_clear, result_irq_enable, result_ready_flag, result_irq;
    logic [31:0] rng;
    logic [11:0] exp_q[$];
    int          err_count, n_compared, dma_cnt, cyc, d0;
    acs_sequencer u_dut (.*);
    acs_far_model u_far (.*);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task summarize();
        if (err_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task tk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task wr_e(input logic [3:0] sl, input logic l);
        tk(1);
        {ctl_wr, ctl_wr_slot, ctl_wr_channel_select} = {1'b1, sl, sl};
        {ctl_wr_reference_select, ctl_wr_last_in_chain} = {sl[2:0], l};
        tk(1);
        ctl_wr = 1'b0;
    endtask
    task go();
        tk(1);
        {soft_start, fire} = {use_soft_start, !use_soft_start};
        tk(1);
        {soft_start, fire} = 2'b00;
    endtask
    task idle();
        int k;
        k = 0;
        tk(2);
        while (busy !== 1'b0 && k < 3000)
        begin
            tk(1);
            k++;
        end
        if (busy !== 1'b0)
            err_count++;
        tk(1);
    endtask
    task rd(input logic [3:0] sl);
        tk(1);
        {slot_rd, slot_rd_idx} = {1'b1, sl};
        exp_q.push_back({seed, sl});
        tk(1);
        slot_rd = 1'b0;
    endtask
    // Read data is registered, so it is judged one edge after the request
    always @(posedge clk)
    begin
        if (rd_d === 1'b1)
        begin
            e_v = exp_q.pop_front();
            `CHK("slot_rd_data", e_v, slot_rd_data)
        end
        rd_d <= slot_rd;
        dma_cnt += (dma_trigger === 1'b1);
        cyc++;
        if (cyc > 20000)
        begin
            err_count++;
            summarize();
        end
    end
    initial
    begin
        {rst, conversion_arm, soft_start, use_soft_start, sample_timer_en, fire} = 6'h20;
        {auto_successive, ctl_wr, ctl_wr_last_in_chain, slot_rd, global_irq_enable} = '0;
        {overrun_clear, trig_overrun_clear, sequence_kind, first_slot_select} = '0;
        {ctl_wr_slot, ctl_wr_channel_select, slot_rd_idx, ctl_wr_reference_select} = '0;
        {seed, flag_clear, result_irq_enable} = '0;
        {err_count, n_compared, dma_cnt, cyc} = '0;
        rng = 32'h0000_0003;
        tk(4);
        rst = 1'b0;
        `CHK("flags", 16'h0000, result_ready_flag)
        for (int i = 0; i < 16; i++)
            wr_e(i[3:0], i == 1);
        rng = xs(rng);
        {seed, result_irq_enable, global_irq_enable} = {rng[7:0], rng[31:16], 1'b1};
        {first_slot_select, use_soft_start, conversion_arm} = {4'h5, 2'b11};
        go();
        idle();
        `CHK("flags", 16'h0020, result_ready_flag)
        go();
        idle();
        `CHK("overrun", 1'b1, result_overrun)
        `CHK("dma", 2, dma_cnt)
        rd(4'h5);
        tk(1);
        `CHK("flags", 16'h0000, result_ready_flag)
        go();
        tk(3);
        go();
        idle();
        `CHK("trig_overrun", 1'b1, trigger_overrun)
        rd(4'h5);
        go();
        tk(6);
        conversion_arm = 1'b0;
        tk(1);
        `CHK("busy", 1'b0, busy)
        {first_slot_select, sequence_kind, auto_successive} = {4'he, 2'b01, 1'b1};
        {sample_timer_en, use_soft_start, d0} = {2'b10, dma_cnt};
        tk(1);
        conversion_arm = 1'b1;
        go();
        idle();
        `CHK("flags", 16'hc003, result_ready_flag)
        `CHK("irq", 16'hc003 & result_irq_enable, result_irq)
        `CHK("dma", d0 + 1, dma_cnt)
        for (int i = 0; i < 4; i++)
        begin
            s = 4'he + i[3:0];
            rd(s);
        end
        go();
        tk(4);
        `CHK("busy", 1'b0, busy)
        conversion_arm = 1'b0;
        tk(1);
        {sequence_kind, conversion_arm} = {2'b11, 1'b1};
        go();
        tk(8);
        {sequence_kind, conversion_arm} = 3'h0;
        tk(1);
        `CHK("busy", 1'b0, busy)
        {first_slot_select, sequence_kind, use_soft_start} = {4'h5, 2'b10, 1'b1};
        tk(1);
        conversion_arm = 1'b1;
        go();
        tk(20);
        conversion_arm = 1'b0;
        tk(1);
        `CHK("busy", 1'b1, busy)
        idle();
        `CHK("flag5", 1'b1, result_ready_flag[5])
        tk(60);
        `CHK("busy", 1'b0, busy)
        flag_clear = 16'h0020;
        tk(1);
        flag_clear = 16'h0000;
        `CHK("flags", 16'h0000, result_ready_flag)
        `CHK("reference", 3'h5, active_reference)
        `CHK("channel", 4'h5, active_channel)
        {first_slot_select, sequence_kind, conversion_arm} = {4'ha, 3'b001};
        go();
        tk(2);
        `CHK("temp", 1'b1, temp_sensor_on)
        `CHK("refgen", 1'b1, ref_gen_on)
        idle();
        `CHK("flag10", 1'b1, result_ready_flag[10])
        tk(2);
        summarize();
    end
endmodule
`default_nettype wire
